/* pwm_pkg.sv */
// Package: register map, config field layout and bus types for the PWM unit
package pwm_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int CHANNELS   = 4;
   localparam int CNT_W      = 10;
   localparam int SETUP_W    = 12;
   localparam int ADDR_W     = 6;
   localparam int DATA_W     = 32;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one word per register)
   // Per channel n: base CH_STRIDE * n
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] START_OFS    = 6'h00;
   localparam logic [ADDR_W-1:0] FLIP_OFS     = 6'h04;
   localparam logic [ADDR_W-1:0] READBACK_OFS = 6'h08;
   localparam logic [ADDR_W-1:0] CH_STRIDE    = 6'h0C;
   localparam logic [ADDR_W-1:0] SETUP_OFS    = 6'h30;

   // ----------------------------------------------------------------
   // Shared setup register: three bits per channel at 3*n
   // bit 0 enable, bit 1 clock select (0 mclk, 1 mclk/PRESCALE),
   // bit 2 phase invert
   // ----------------------------------------------------------------
   localparam int FLD_W      = 3;
   localparam int FLD_EN     = 0;
   localparam int FLD_CLKSEL = 1;
   localparam int FLD_PHASE  = 2;
   localparam logic [SETUP_W-1:0] SETUP_RESET = 12'h000;
   localparam logic [CNT_W-1:0]   CNT_RESET   = 10'h000;
   localparam logic [CNT_W-1:0]   CNT_MAX     = 10'h3FF;

   // Slow clock tick period in mclk cycles (1 us at 100 MHz)
   localparam int MCLK_MHZ     = 100;
   localparam int SLOW_TICK_NS = 1000;
   localparam int PRESCALE     = SLOW_TICK_NS * MCLK_MHZ / 1000;
   localparam int PRE_W        = 7;

   // ----------------------------------------------------------------
   // Bus types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic              read;
      logic              write;
      logic [3:0]        byteenable;
      logic [DATA_W-1:0] writedata;
   } avm_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic              waitrequest;
   } avm_rsp_t;

   typedef struct packed {
      logic             enable;
      logic             slowClk;
      logic             invert;
      logic [CNT_W-1:0] startCount;
      logic [CNT_W-1:0] flipPoint;
   } chan_cfg_t;

endpackage

/* pwm_channel.sv */
// One PWM channel: counter, reload and output toggle
`timescale 1ns/1ps
`default_nettype none
module pwm_channel (
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   input  wire pwm_pkg::chan_cfg_t     cfg,
   input  wire logic                   slowTick,
   output logic [pwm_pkg::CNT_W-1:0]   count,
   output logic                        pwmOut
);
   import pwm_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             level;
   } ch_state_t;

   ch_state_t state_r;
   ch_state_t state_nxt;
   logic      step;

   always_comb begin
      state_nxt = state_r;
      step      = cfg.slowClk ? slowTick : 1'b1;
      if (!cfg.enable) begin
         state_nxt.cnt   = cfg.startCount;
         state_nxt.level = 1'b0;
      end else if (step) begin
         if (state_r.cnt == CNT_MAX) begin
            state_nxt.cnt   = cfg.startCount;
            state_nxt.level = 1'b0;
         end else begin
            state_nxt.cnt = state_r.cnt + 10'h001;
         end
         if (state_r.cnt == cfg.flipPoint) begin
            state_nxt.level = ~state_r.level;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign count  = state_r.cnt;
   assign pwmOut = state_r.level ^ cfg.invert;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_WRAP_RELOAD: assert property (@(posedge mclk) disable iff (!reset_n)
      (cfg.enable && step && state_r.cnt == CNT_MAX)
      ##1 $stable(cfg.startCount) |-> state_r.cnt == cfg.startCount)
      else $error("counter did not reload after max");
   AST_ADVANCE: assert property (@(posedge mclk) disable iff (!reset_n)
      (cfg.enable && step && state_r.cnt != CNT_MAX)
      |=> state_r.cnt == $past(state_r.cnt) + 10'h001)
      else $error("counter did not advance");
   AST_TOGGLE: assert property (@(posedge mclk) disable iff (!reset_n)
      (cfg.enable && step && state_r.cnt == cfg.flipPoint
       && state_r.cnt != CNT_MAX)
      |=> state_r.level != $past(state_r.level))
      else $error("output did not toggle at flip point");
endmodule
`default_nettype wire

/* four_channel_pwm_unit.sv */
// Four-channel PWM unit with Avalon-MM register slave
// How it works
// - Four independent PWM channels, numbered zero to three.
// - Each channel has a 10-bit start count register, read and write.
// - Each channel has a 10-bit flip point register, read and write.
// - Each channel's live 10-bit counter is readable, not writable.
// - One 12-bit setup register, read and write, shared by all channels.
// - Setup holds per-channel enable, clock select and phase invert.
// - Channel zero drives port bit 26, channel one port bit 27.
// - Channel two drives port bit 28, channel three port bit 29.
`timescale 1ns/1ps
`default_nettype none
module four_channel_pwm_unit #(
   parameter int NUM_CH = pwm_pkg::CHANNELS
) (
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire pwm_pkg::avm_req_t avmReq,
   output pwm_pkg::avm_rsp_t      avmRsp,
   output logic                   port_bit_26,
   output logic                   port_bit_27,
   output logic                   port_bit_28,
   output logic                   port_bit_29
);
   import pwm_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0][CNT_W-1:0] startCount;
      logic [NUM_CH-1:0][CNT_W-1:0] flipPoint;
      logic [SETUP_W-1:0]           setup;
      logic [PRE_W-1:0]             pre;
      logic                         slowTick;
      logic [DATA_W-1:0]            rdata;
      logic                         ack;
   } unit_state_t;

   unit_state_t state_r;
   unit_state_t state_nxt;

   logic [NUM_CH-1:0][CNT_W-1:0] liveCount;
   logic [NUM_CH-1:0]            chanOut;
   chan_cfg_t [NUM_CH-1:0]       chanCfg;

   // ----------------------------------------------------------------
   // Register access and prescaler
   // ----------------------------------------------------------------
   // One wait state per access: the request is taken on the cycle
   // ack is low and answered with waitrequest low one cycle later.
   always_comb begin
      logic             hit;
      logic [CNT_W-1:0] wv;
      logic [SETUP_W-1:0] sv;
      hit       = 1'b0;
      wv        = '0;
      sv        = '0;
      state_nxt = state_r;
      state_nxt.ack      = 1'b0;
      state_nxt.slowTick = 1'b0;
      if (state_r.pre == PRE_W'(PRESCALE - 1)) begin
         state_nxt.pre      = '0;
         state_nxt.slowTick = 1'b1;
      end else begin
         state_nxt.pre = state_r.pre + 7'h01;
      end
      // Decode in both cycles; writes commit on the answer edge only
      if (avmReq.read || avmReq.write) begin
         state_nxt.ack   = !state_r.ack;
         state_nxt.rdata = '0;
         for (int n = 0; n < NUM_CH; n++) begin
            wv = state_r.startCount[n];
            if (avmReq.byteenable[0]) begin
               wv[7:0] = avmReq.writedata[7:0];
            end
            if (avmReq.byteenable[1]) begin
               wv[CNT_W-1:8] = avmReq.writedata[CNT_W-1:8];
            end
            if (avmReq.address == ADDR_W'(n * CH_STRIDE) + START_OFS) begin
               hit = 1'b1;
               state_nxt.rdata = DATA_W'(state_r.startCount[n]);
               if (avmReq.write && state_r.ack) begin
                  state_nxt.startCount[n] = wv;
               end
            end else if (avmReq.address ==
                         ADDR_W'(n * CH_STRIDE) + FLIP_OFS) begin
               hit = 1'b1;
               wv = state_r.flipPoint[n];
               if (avmReq.byteenable[0]) begin
                  wv[7:0] = avmReq.writedata[7:0];
               end
               if (avmReq.byteenable[1]) begin
                  wv[CNT_W-1:8] = avmReq.writedata[CNT_W-1:8];
               end
               state_nxt.rdata = DATA_W'(state_r.flipPoint[n]);
               if (avmReq.write && state_r.ack) begin
                  state_nxt.flipPoint[n] = wv;
               end
            end else if (avmReq.address ==
                         ADDR_W'(n * CH_STRIDE) + READBACK_OFS) begin
               hit = 1'b1;
               state_nxt.rdata = DATA_W'(liveCount[n]);
            end
         end
         if (avmReq.address == SETUP_OFS) begin
            hit = 1'b1;
            sv = state_r.setup;
            if (avmReq.byteenable[0]) begin
               sv[7:0] = avmReq.writedata[7:0];
            end
            if (avmReq.byteenable[1]) begin
               sv[SETUP_W-1:8] = avmReq.writedata[SETUP_W-1:8];
            end
            state_nxt.rdata = DATA_W'(state_r.setup);
            if (avmReq.write && state_r.ack) begin
               state_nxt.setup = sv;
            end
         end
         if (!hit) begin
            state_nxt.rdata = '0;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= '0;
         state_r.setup <= SETUP_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign avmRsp.waitrequest = !state_r.ack;
   assign avmRsp.readdata    = state_r.rdata;

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
      assign chanCfg[g].enable  = state_r.setup[FLD_W*g + FLD_EN];
      assign chanCfg[g].slowClk = state_r.setup[FLD_W*g + FLD_CLKSEL];
      assign chanCfg[g].invert  = state_r.setup[FLD_W*g + FLD_PHASE];
      assign chanCfg[g].startCount = state_r.startCount[g];
      assign chanCfg[g].flipPoint  = state_r.flipPoint[g];
      pwm_channel u_ch (
         .mclk     (mclk),
         .reset_n  (reset_n),
         .cfg      (chanCfg[g]),
         .slowTick (state_r.slowTick),
         .count    (liveCount[g]),
         .pwmOut   (chanOut[g])
      );
   end

   assign port_bit_26 = chanOut[0];
   assign port_bit_27 = chanOut[1];
   assign port_bit_28 = chanOut[2];
   assign port_bit_29 = chanOut[3];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_WAIT_ONE: assert property (@(posedge mclk) disable iff (!reset_n)
      ((avmReq.read || avmReq.write) && avmRsp.waitrequest)
      |=> !avmRsp.waitrequest)
      else $error("slave did not answer in one cycle");
   AST_SETUP_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
      (avmReq.write && !avmRsp.waitrequest && avmReq.address == SETUP_OFS
       && avmReq.byteenable[1:0] == 2'b11)
      |=> state_r.setup == $past(avmReq.writedata[SETUP_W-1:0]))
      else $error("setup register write lost");
   AST_RB_RO: assert property (@(posedge mclk) disable iff (!reset_n)
      (avmReq.read && avmRsp.waitrequest
       && avmReq.address == READBACK_OFS)
      |=> avmRsp.readdata == DATA_W'($past(liveCount[0])))
      else $error("counter readback wrong");
   AST_START_RD: assert property (@(posedge mclk) disable iff (!reset_n)
      (avmReq.read && avmRsp.waitrequest && avmReq.address == START_OFS)
      |=> avmRsp.readdata == DATA_W'($past(state_r.startCount[0])))
      else $error("start count readback wrong");
   AST_FLIP_RD: assert property (@(posedge mclk) disable iff (!reset_n)
      (avmReq.read && avmRsp.waitrequest && avmReq.address == FLIP_OFS)
      |=> avmRsp.readdata == DATA_W'($past(state_r.flipPoint[0])))
      else $error("flip point readback wrong");
   AST_PORT_MAP: assert property (@(posedge mclk) disable iff (!reset_n)
      {port_bit_29, port_bit_28, port_bit_27, port_bit_26} == chanOut)
      else $error("port bit mapping wrong");
   AST_IDLE_LOW: assert property (@(posedge mclk) disable iff (!reset_n)
      (!state_r.setup[FLD_EN] && !state_r.setup[FLD_PHASE])
      ##1 (!state_r.setup[FLD_EN] && !state_r.setup[FLD_PHASE])
      |-> !port_bit_26)
      else $error("disabled channel output not idle");
   AST_TICK_RATE: assert property (@(posedge mclk) disable iff (!reset_n)
      state_r.slowTick |=> !state_r.slowTick ##1 !state_r.slowTick)
      else $error("slow tick too frequent");
endmodule
`default_nettype wire

/* led_load_model.sv */
// LED load model: counts lit cycles on the four PWM port bits
`timescale 1ns/1ps
`default_nettype none
module led_load_model (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             measure,
   input  wire logic [3:0]       pins,
   output logic      [3:0][15:0] litCount
);
   logic measPrev;
   // ----------------------------------------------------------------
   // Lit-cycle counters, restarted as each window opens
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         measPrev <= 1'b0;
         litCount <= '0;
      end else begin
         measPrev <= measure;
         for (int i = 0; i < 4; i++) begin
            if (measure && !measPrev)
               litCount[i] <= {15'h0, pins[i]};
            else if (measure)
               litCount[i] <= litCount[i] + {15'h0, pins[i]};
         end
      end
   end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the four-channel PWM unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pwm_pkg::*;
   logic             mclk = 1'b0;
   logic             reset_n;
   avm_req_t         avmReq;
   avm_rsp_t         avmRsp;
   logic             port_bit_26;
   logic             port_bit_27;
   logic             port_bit_28;
   logic             port_bit_29;
   logic             measure;
   logic [3:0][15:0] litCount;
   logic [31:0]      rd;
   int               err_total = 0;
   int               cmp_count = 0;
   int               cycles = 0;
   // ----------------------------------------------------------------
   // Table rows: address, write data, value read back after it
   // ----------------------------------------------------------------
   localparam logic [5:0] ADDRS [6] = '{6'h00, 6'h10, 6'h18, 6'h20, 6'h3C,
                                        6'h30};
   localparam logic [31:0] WDATA [6] = '{32'hFFFFFFFF, 32'h00012345,
      32'h000002AA, 32'h00000155, 32'h0000005A, 32'h0000FFFF};
   localparam logic [31:0] EXPECT [6] = '{32'h3FF, 32'h345, 32'h2AA,
      32'h2AA, 32'h000, 32'hFFF};

   always #5 mclk = ~mclk;

   four_channel_pwm_unit uut (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .avmReq      (avmReq),
      .avmRsp      (avmRsp),
      .port_bit_26 (port_bit_26),
      .port_bit_27 (port_bit_27),
      .port_bit_28 (port_bit_28),
      .port_bit_29 (port_bit_29)
   );

   led_load_model load (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .measure  (measure),
      .pins     ({port_bit_29, port_bit_28, port_bit_27, port_bit_26}),
      .litCount (litCount)
   );

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Holds the request until waitrequest is seen low at an edge
   task automatic busOp(input logic wr, input logic [5:0] addr,
                        input logic [31:0] wdata);
      int n;
      n = 0;
      @(posedge mclk);
      avmReq.address <= addr;
      avmReq.write <= wr;
      avmReq.read <= !wr;
      avmReq.writedata <= wdata;
      do begin
         @(posedge mclk);
         n++;
      end while (avmRsp.waitrequest !== 1'b0 && n < 50);
      rd = avmRsp.readdata;
      if (n >= 50) begin
         err_total++;
         $display("[ERR] waitrequest expected 0 seen 1");
      end
      avmReq.read <= 1'b0;
      avmReq.write <= 1'b0;
   endtask

   // Extra edge at the end lets the last count land
   task automatic window(input int len);
      @(posedge mclk);
      measure <= 1'b1;
      repeat (len) @(posedge mclk);
      measure <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Longest path is the slow-clock window, about 16000 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         err_total++;
         $display("[ERR] run length expected done seen hang");
         stop_test();
      end
   end

   initial begin
      avmReq = '0;
      avmReq.byteenable = 4'hF;
      measure = 1'b0;
      reset_n = 1'b0;
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      for (int a = 0; a <= 48; a += 4) begin
         busOp(1'b0, 6'(a), 32'h0);
         check("reset value", rd, 32'h0);
      end
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         busOp(1'b1, ADDRS[i], WDATA[i]);
         busOp(1'b0, ADDRS[i], 32'h0);
         check("register readback", rd, EXPECT[i]);
      end
      $display("test register table done");
      // Low byte lane only: upper bits of the start count must survive
      avmReq.byteenable <= 4'h1;
      busOp(1'b1, START_OFS, 32'h00000000);
      avmReq.byteenable <= 4'hF;
      busOp(1'b0, START_OFS, 32'h0);
      check("byte lane write", rd, 32'h300);
      $display("test byte lanes done");
      // Disable first so every counter restarts from its start count
      busOp(1'b1, SETUP_OFS, 32'h0);
      for (int n = 0; n < 4; n++) begin
         busOp(1'b1, 6'(n * 12) + START_OFS, 32'h3F0);
         busOp(1'b1, 6'(n * 12) + FLIP_OFS, 32'h3F8 - 32'(n));
      end
      busOp(1'b1, SETUP_OFS, 32'hA49);
      repeat (100) @(posedge mclk);
      busOp(1'b0, READBACK_OFS, 32'h0);
      check("live count", 32'(rd >= 32'h3F0 && rd <= 32'h3FF), 32'h1);
      window(160);
      for (int n = 0; n < 3; n++)
         check("lit cycles", {16'h0, litCount[n]}, 32'h46 + 32'hA * n);
      check("inverted lit cycles", {16'h0, litCount[3]}, 32'h3C);
      $display("test fast channels done");
      busOp(1'b1, SETUP_OFS, 32'h003);
      repeat (3300) @(posedge mclk);
      window(16000);
      check("slow lit cycles", {16'h0, litCount[0]}, 32'h1B58);
      check("disabled lit cycles", {16'h0, litCount[1]}, 32'h0);
      $display("test slow clock done");
      stop_test();
   end
endmodule
`default_nettype wire
